// file: hdl/dct_pkg.sv
// Constants, encodings and state record for the dual counter block
package dct_pkg;

   localparam int unsigned SHORT_W    = 8;
   localparam int unsigned LONG_W     = 16;
   localparam int unsigned ADDR_W     = 4;
   localparam int unsigned GLITCH_CW  = 8;

   // Register offsets
   localparam logic [ADDR_W-1:0] ADDR_SHORT_CTL   = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_SHARED_CTL  = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_LONG_CTL    = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_SHORT_LOW   = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_SHORT_HIGH  = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_POS_CAP     = 4'h5;
   localparam logic [ADDR_W-1:0] ADDR_NEG_CAP     = 4'h6;
   localparam logic [ADDR_W-1:0] ADDR_LONG_RLD_LO = 4'h7;
   localparam logic [ADDR_W-1:0] ADDR_LONG_RLD_HI = 4'h8;

   // Counter control fields (short and long control registers)
   localparam int unsigned BIT_EN      = 7;
   localparam int unsigned BIT_ONESHOT = 6;
   localparam int unsigned BIT_TIMEOUT = 5;
   localparam int unsigned BIT_CAP_IE  = 2;
   localparam int unsigned BIT_TO_IE   = 1;

   // Shared control fields
   localparam int unsigned BIT_MODE       = 7;
   localparam int unsigned FLD_FUNC_LSB   = 4;
   localparam int unsigned FLD_SUB_LSB    = 2;
   localparam int unsigned BIT_SHORT_INIT = 1;
   localparam int unsigned BIT_LONG_INIT  = 0;

   localparam logic [SHORT_W-1:0] SHORT_ALL_ONES = 8'hff;
   localparam logic [SHORT_W-1:0] SHORT_TERMINAL = 8'h01;
   localparam logic [LONG_W-1:0]  LONG_TERMINAL  = 16'h0001;

   typedef enum logic [1:0] {
      FUNC_AND = 2'h0, FUNC_OR = 2'h1, FUNC_NOR = 2'h2, FUNC_NAND = 2'h3
   } dct_func_t;

   // Demodulation edge choice shares the function field; 1x means both edges
   localparam logic [1:0] EDGE_FALL = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;

   typedef enum logic [1:0] {
      SUB_NORMAL = 2'h0, SUB_ALT = 2'h1, SUB_FORCE_LO = 2'h2, SUB_FORCE_HI = 2'h3
   } dct_sub_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00, S_ARM = 2'b01, S_RUN = 2'b11, S_HOLD = 2'b10
   } dct_short_st_t;

   typedef enum logic [1:0] {
      L_IDLE = 2'b00, L_RUN = 2'b01, L_HOLD = 2'b11
   } dct_long_st_t;

   typedef struct packed {
      logic [7:0]           short_ctl;
      logic [7:0]           shared_ctl;
      logic [7:0]           long_ctl;
      logic [SHORT_W-1:0]   short_low;
      logic [SHORT_W-1:0]   short_high;
      logic [SHORT_W-1:0]   pos_cap;
      logic [SHORT_W-1:0]   neg_cap;
      logic [7:0]           long_rld_lo;
      logic [7:0]           long_rld_hi;
      logic                 rise_flag;
      logic                 fall_flag;
      dct_short_st_t        short_st;
      dct_long_st_t         long_st;
      logic [SHORT_W-1:0]   short_cnt;
      logic [LONG_W-1:0]    long_cnt;
      logic                 short_en_q;
      logic                 long_en_q;
      logic                 kick_short;
      logic                 kick_long;
      logic                 short_out;
      logic                 long_out;
      logic                 comb_out;
      logic                 filt;
      logic                 filt_q;
      logic [GLITCH_CW-1:0] glitch_cnt;
      logic [7:0]           rdata;
      logic                 timeout_irq;
      logic                 capture_irq;
   } dct_state_t;

endpackage : dct_pkg

// file: hdl/dct_counter_pair.sv
// Dual down-counter with transmit and demodulation modes
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps

// Summary of operation
// - Transmit: function field merges short and long outputs by AND, OR, NOR, NAND.
// - Demodulation: same field picks rising, falling or both edges.
// - Transmit submode picks alternating or normal; normal ends alternating.
// - Submode 10 forces long output low at once, 11 forces it high.
// - Demodulation: submode sets glitch width removed before edge detection.
// - Short initial level applied at start; opposite level held while disabled.
// - Demodulation: rising edge sets rise flag; writing 1 clears it.
// - Long initial level likewise, effective only in normal or alternating submode.
// - Demodulation: falling edge sets fall flag; writing 1 clears it.
// - Short start loads low reload if initial level 0, else high reload.
// - One-shot: count to terminal, stop, toggle, set timeout, interrupt if enabled.
// - Repeating: toggle, timeout, reload by new output level, continue.
// - Reload registers rewritten any time take effect at next load.
// - Short count 0 wraps to FFh, long count 0 to FFFFh, without a timeout.
// - Demodulation: counting starts only at the first selected edge.
// - Later edges capture complemented count, set flag, interrupt if enabled, reload FFh.
// - Rising-edge captures go to positive register, falling to negative.
// - Demodulation timeout sets status, interrupts if enabled, continues from FFh.
module dct_counter_pair
   import dct_pkg::*;
#(
   parameter int unsigned GLITCH_W1 = 2,
   parameter int unsigned GLITCH_W2 = 4,
   parameter int unsigned GLITCH_W3 = 8
) (
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata,
   input  wire logic              edge_in,
   output logic                   short_counter_output,
   output logic                   long_counter_output,
   output logic                   combined_output,
   output logic                   timeout_irq_req,
   output logic                   capture_irq_req
);

   if (GLITCH_W1 > 255 || GLITCH_W2 > 255 || GLITCH_W3 > 255) begin : g_bad_width
      $error("Glitch widths must fit in eight bits");
   end

   dct_state_t           s;
   dct_state_t           next_s;

   logic                 demod;
   dct_sub_t             sub;
   logic [1:0]           fsel;
   logic                 alt;
   logic [GLITCH_CW-1:0] glitch_w;
   logic                 rise;
   logic                 fall;
   logic                 sel_rise;
   logic                 sel_fall;
   logic                 short_edge;
   logic                 short_en;
   logic                 long_en;
   logic                 short_init;
   logic                 long_init;
   logic                 short_to;
   logic                 long_to;
   logic [LONG_W-1:0]    long_reload;

   always_comb begin
      next_s      = s;
      next_s.rdata       = 8'h00;
      next_s.timeout_irq = 1'b0;
      next_s.capture_irq = 1'b0;
      next_s.kick_short  = 1'b0;
      next_s.kick_long   = 1'b0;
      short_to    = 1'b0;
      long_to     = 1'b0;

      demod       = s.shared_ctl[BIT_MODE];
      sub         = dct_sub_t'(s.shared_ctl[FLD_SUB_LSB +: 2]);
      fsel        = s.shared_ctl[FLD_FUNC_LSB +: 2];
      alt         = !demod && sub == SUB_ALT;
      short_en    = s.short_ctl[BIT_EN];
      long_en     = s.long_ctl[BIT_EN];
      short_init  = s.shared_ctl[BIT_SHORT_INIT];
      long_init   = s.shared_ctl[BIT_LONG_INIT];
      long_reload = {s.long_rld_hi, s.long_rld_lo};

      // Register writes; hardware events below override clears
      if (reg_wr) begin
         case (reg_addr)
            ADDR_SHORT_CTL: begin
               next_s.short_ctl = reg_wdata;
               next_s.short_ctl[BIT_TIMEOUT] = s.short_ctl[BIT_TIMEOUT] & ~reg_wdata[BIT_TIMEOUT];
            end
            ADDR_SHARED_CTL: begin
               next_s.shared_ctl[7:2] = reg_wdata[7:2];
               if (reg_wdata[BIT_MODE]) begin
                  next_s.rise_flag = s.rise_flag & ~reg_wdata[BIT_SHORT_INIT];
                  next_s.fall_flag = s.fall_flag & ~reg_wdata[BIT_LONG_INIT];
               end else begin
                  next_s.shared_ctl[1:0] = reg_wdata[1:0];
               end
            end
            ADDR_LONG_CTL: begin
               next_s.long_ctl = reg_wdata;
               next_s.long_ctl[BIT_TIMEOUT] = s.long_ctl[BIT_TIMEOUT] & ~reg_wdata[BIT_TIMEOUT];
            end
            // reloads only stored here, used at next load
            ADDR_SHORT_LOW:   next_s.short_low   = reg_wdata;
            ADDR_SHORT_HIGH:  next_s.short_high  = reg_wdata;
            ADDR_LONG_RLD_LO: next_s.long_rld_lo = reg_wdata;
            ADDR_LONG_RLD_HI: next_s.long_rld_hi = reg_wdata;
            default: ;
         endcase
      end

      if (reg_rd) begin
         case (reg_addr)
            ADDR_SHORT_CTL:   next_s.rdata = s.short_ctl;
            ADDR_SHARED_CTL:  next_s.rdata = demod ? {s.shared_ctl[7:2], s.rise_flag, s.fall_flag}
                                                   : s.shared_ctl;
            ADDR_LONG_CTL:    next_s.rdata = s.long_ctl;
            ADDR_SHORT_LOW:   next_s.rdata = s.short_low;
            ADDR_SHORT_HIGH:  next_s.rdata = s.short_high;
            ADDR_POS_CAP:     next_s.rdata = s.pos_cap;
            ADDR_NEG_CAP:     next_s.rdata = s.neg_cap;
            ADDR_LONG_RLD_LO: next_s.rdata = s.long_rld_lo;
            ADDR_LONG_RLD_HI: next_s.rdata = s.long_rld_hi;
            default:          next_s.rdata = 8'h00;
         endcase
      end

      // glitch width by submode, demodulation only
      case (sub)
         SUB_ALT:      glitch_w = GLITCH_CW'(GLITCH_W1);
         SUB_FORCE_LO: glitch_w = GLITCH_CW'(GLITCH_W2);
         SUB_FORCE_HI: glitch_w = GLITCH_CW'(GLITCH_W3);
         default:      glitch_w = '0;
      endcase
      if (!demod) begin
         glitch_w = '0;
      end
      // input must differ longer than the width to pass
      if (edge_in != s.filt) begin
         if (s.glitch_cnt >= glitch_w) begin
            next_s.filt       = edge_in;
            next_s.glitch_cnt = '0;
         end else begin
            next_s.glitch_cnt = s.glitch_cnt + 1'b1;
         end
      end else begin
         next_s.glitch_cnt = '0;
      end
      next_s.filt_q = s.filt;
      rise          = s.filt & ~s.filt_q;
      fall          = ~s.filt & s.filt_q;
      sel_rise      = fsel == EDGE_RISE || fsel[1];
      sel_fall      = fsel == EDGE_FALL || fsel[1];
      short_edge    = (rise && sel_rise) || (fall && sel_fall);

      // Short counter
      next_s.short_en_q = short_en;
      if (!short_en) begin
         next_s.short_st = S_IDLE;
         if (!demod) begin
            next_s.short_out = ~short_init;
         end
      end else if (!s.short_en_q) begin
         if (demod) begin
            next_s.short_st  = S_ARM;
            next_s.short_cnt = SHORT_ALL_ONES;
         end else begin
            next_s.short_out = short_init;
            next_s.short_cnt = short_init ? s.short_high : s.short_low;
            next_s.short_st  = S_RUN;
         end
      end else begin
         case (s.short_st)
            S_ARM: begin
               if (short_edge) begin
                  next_s.short_st = S_RUN;
               end
            end
            S_RUN: begin
               if (demod) begin
                  if (short_edge) begin
                     if (rise) begin
                        next_s.pos_cap = ~s.short_cnt;
                        next_s.rise_flag = 1'b1;
                     end else begin
                        next_s.neg_cap = ~s.short_cnt;
                        next_s.fall_flag = 1'b1;
                     end
                     next_s.short_cnt   = SHORT_ALL_ONES;
                     next_s.capture_irq = s.short_ctl[BIT_CAP_IE];
                  end else if (s.short_cnt == SHORT_TERMINAL) begin
                     short_to         = 1'b1;
                     next_s.short_cnt = SHORT_ALL_ONES;
                  end else begin
                     next_s.short_cnt = s.short_cnt - 1'b1;
                  end
               end else if (s.short_cnt == SHORT_TERMINAL) begin
                  // terminal count toggles and times out
                  short_to         = 1'b1;
                  next_s.short_out = ~s.short_out;
                  if (alt) begin
                     // hand over to the long counter
                     next_s.short_st  = S_HOLD;
                     next_s.kick_long = 1'b1;
                  end else if (s.short_ctl[BIT_ONESHOT]) begin
                     next_s.short_st = S_IDLE;
                  end else begin
                     next_s.short_cnt = s.short_out ? s.short_low : s.short_high;
                  end
               end else begin
                  next_s.short_cnt = s.short_cnt - 1'b1;
               end
            end
            S_HOLD: begin
               if (s.kick_short || !alt) begin
                  next_s.short_cnt = s.short_out ? s.short_high : s.short_low;
                  next_s.short_st  = S_RUN;
               end
            end
            default: ;
         endcase
      end

      // Long counter, transmit only
      next_s.long_en_q = long_en;
      if (!long_en || demod) begin
         next_s.long_st = L_IDLE;
         next_s.long_out = ~long_init;
      end else if (!s.long_en_q) begin
         next_s.long_out = long_init;
         next_s.long_cnt = long_reload;
         next_s.long_st  = alt ? L_HOLD : L_RUN;
      end else begin
         case (s.long_st)
            L_RUN: begin
               if (s.long_cnt == LONG_TERMINAL) begin
                  long_to         = 1'b1;
                  next_s.long_out = ~s.long_out;
                  next_s.long_cnt = long_reload;
                  if (alt) begin
                     // hand back to the short counter
                     next_s.long_st    = L_HOLD;
                     next_s.kick_short = 1'b1;
                  end else if (s.long_ctl[BIT_ONESHOT]) begin
                     next_s.long_st = L_IDLE;
                  end
               end else begin
                  next_s.long_cnt = s.long_cnt - 1'b1;
               end
            end
            L_HOLD: begin
               if (s.kick_long || !alt) begin
                  next_s.long_st = L_RUN;
               end
            end
            default: ;
         endcase
      end

      if (!demod && sub == SUB_FORCE_LO) begin
         next_s.long_out = 1'b0;
      end else if (!demod && sub == SUB_FORCE_HI) begin
         next_s.long_out = 1'b1;
      end

      // timeout status set wins over clear
      next_s.short_ctl[BIT_TIMEOUT] = next_s.short_ctl[BIT_TIMEOUT] | short_to;
      next_s.long_ctl[BIT_TIMEOUT]  = next_s.long_ctl[BIT_TIMEOUT] | long_to;
      next_s.timeout_irq = (short_to && s.short_ctl[BIT_TO_IE])
                        || (long_to && s.long_ctl[BIT_TO_IE]);

      case (dct_func_t'(fsel))
         FUNC_AND:  next_s.comb_out = next_s.short_out & next_s.long_out;
         FUNC_OR:   next_s.comb_out = next_s.short_out | next_s.long_out;
         FUNC_NOR:  next_s.comb_out = ~(next_s.short_out | next_s.long_out);
         FUNC_NAND: next_s.comb_out = ~(next_s.short_out & next_s.long_out);
         default:   next_s.comb_out = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s <= dct_state_t'('0);
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata            = s.rdata;
   assign short_counter_output = s.short_out;
   assign long_counter_output  = s.long_out;
   assign combined_output      = s.comb_out;
   assign timeout_irq_req      = s.timeout_irq;
   assign capture_irq_req      = s.capture_irq;

endmodule : dct_counter_pair

// file: verif/dct_monitor.sv
// Port assertions for the dual counter block
`timescale 1ns/1ps
module dct_monitor
   import dct_pkg::*;
(
   input wire logic              clk_sys,
   input wire logic              sys_rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0]        reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [7:0]        reg_rdata,
   input wire logic              short_counter_output,
   input wire logic              long_counter_output,
   input wire logic              timeout_irq_req,
   input wire logic              capture_irq_req
);
   logic short_on;
   logic tx_mode;
   logic init_s;

   default clocking mon_cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // Software view of enable, mode and short initial level
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         short_on <= 1'b0;
         tx_mode  <= 1'b1;
         init_s   <= 1'b0;
      end else if (reg_wr && reg_addr == ADDR_SHORT_CTL) begin
         short_on <= reg_wdata[BIT_EN];
      end else if (reg_wr && reg_addr == ADDR_SHARED_CTL) begin
         tx_mode <= !reg_wdata[BIT_MODE];
         if (!reg_wdata[BIT_MODE]) begin
            init_s <= reg_wdata[BIT_SHORT_INIT];
         end
      end
   end

   sequence shared_wr_s;
      reg_wr && reg_addr == ADDR_SHARED_CTL && !reg_wdata[BIT_MODE];
   endsequence
   sequence short_start_s;
      reg_wr && reg_addr == ADDR_SHORT_CTL && reg_wdata[BIT_EN] && !short_on && tx_mode;
   endsequence

   rdata_idle_a:
      assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside read cycle");
   unmapped_read_a:
      assert property (reg_rd && reg_addr > ADDR_LONG_RLD_HI |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   force_low_a:
      assert property (shared_wr_s ##0 reg_wdata[3:2] == SUB_FORCE_LO |-> ##2 !long_counter_output)
      else $error("long output not forced low");
   force_high_a:
      assert property (shared_wr_s ##0 reg_wdata[3:2] == SUB_FORCE_HI |-> ##2 long_counter_output)
      else $error("long output not forced high");
   timeout_pulse_a:
      assert property (timeout_irq_req |=> !timeout_irq_req)
      else $error("timeout request longer than one cycle");
   capture_pulse_a:
      assert property (capture_irq_req |=> !capture_irq_req)
      else $error("capture request longer than one cycle");
   idle_level_a:
      assert property ((!short_on && tx_mode && $stable(init_s)) [*3]
                       |-> short_counter_output == !init_s)
      else $error("idle short output not opposite of initial level");
   start_level_a:
      assert property (short_start_s |-> ##2 short_counter_output == init_s)
      else $error("short output not at initial level after start");
endmodule : dct_monitor

bind dct_counter_pair dct_monitor dct_monitor_i (
   .clk_sys              (clk_sys),
   .sys_rst              (sys_rst),
   .reg_addr             (reg_addr),
   .reg_wdata            (reg_wdata),
   .reg_wr               (reg_wr),
   .reg_rd               (reg_rd),
   .reg_rdata            (reg_rdata),
   .short_counter_output (short_counter_output),
   .long_counter_output  (long_counter_output),
   .timeout_irq_req      (timeout_irq_req),
   .capture_irq_req      (capture_irq_req)
);

// file: verif/tb_top.sv
// Self-checking bench for the dual counter block
`timescale 1ns/1ps
module tb_top
   import dct_pkg::*;
;
   logic              clk_sys = 1'b0;
   logic              sys_rst = 1'b1;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [7:0]        reg_wdata = 8'h00;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [7:0]        reg_rdata;
   logic              edge_in = 1'b0;
   logic              short_out;
   logic              long_out;
   logic              comb_out;
   logic              to_req;
   logic              cap_req;
   int                fail_count = 0;
   int                checks_done = 0;
   int                to_pulses = 0;
   int                cap_pulses = 0;
   int                n;
   logic [7:0]        rv;
   logic [7:0]        cap_pos;
   logic [3:0]        kk;
   logic              exp_c;

   always #20 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      to_pulses  <= to_pulses + int'(to_req === 1'b1);
      cap_pulses <= cap_pulses + int'(cap_req === 1'b1);
   end

   dct_counter_pair dct_counter_pair_i (
      .clk_sys              (clk_sys),
      .sys_rst              (sys_rst),
      .reg_addr             (reg_addr),
      .reg_wdata            (reg_wdata),
      .reg_wr               (reg_wr),
      .reg_rd               (reg_rd),
      .reg_rdata            (reg_rdata),
      .edge_in              (edge_in),
      .short_counter_output (short_out),
      .long_counter_output  (long_out),
      .combined_output      (comb_out),
      .timeout_irq_req      (to_req),
      .capture_irq_req      (cap_req)
   );

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk8

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string w);
      rd(a, rv);
      chk8(rv, e, w);
   endtask : rdchk

   // Counts clock edges until the short output reaches a level
   task automatic wait_short(input logic v, output int cyc);
      cyc = 0;
      while (short_out !== v) begin
         @(posedge clk_sys);
         #1;
         cyc++;
         if (cyc > 1000) begin
            fail_count++;
            $display("mismatch at %0t: short output stuck", $time);
            wrap_up();
         end
      end
   endtask : wait_short

   task automatic edge_to(input logic v, input int c);
      @(posedge clk_sys);
      edge_in <= v;
      repeat (c) @(posedge clk_sys);
   endtask : edge_to

   initial begin
      repeat (100000) @(posedge clk_sys);
      fail_count++;
      $display("mismatch at %0t: run too long", $time);
      wrap_up();
   end

   initial begin
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (int a = 0; a < 9; a++) begin
         rdchk(4'(a), 8'h00, "reset value");
      end
      wr(4'hc, 8'h5a);
      rdchk(4'hc, 8'h00, "unmapped");
      wr(ADDR_POS_CAP, 8'h33);
      rdchk(ADDR_POS_CAP, 8'h00, "capture read only");
      wr(ADDR_LONG_CTL, 8'h42);
      rdchk(ADDR_LONG_CTL, 8'h42, "long control");
      wr(ADDR_LONG_CTL, 8'h00);
      // Every merge function against both forced long levels
      for (int k = 0; k < 16; k++) begin
         kk = 4'(k);
         wr(ADDR_SHARED_CTL, {2'b00, kk[3:2], 1'b1, kk[1], kk[0], 1'b0});
         repeat (4) @(posedge clk_sys);
         #1;
         exp_c = ((kk[3] ^ kk[2]) ? (!kk[0] | kk[1]) : (!kk[0] & kk[1])) ^ kk[3];
         chk8(8'(long_out), 8'(kk[1]), "forced long");
         chk8(8'(short_out), 8'(!kk[0]), "idle short");
         chk8(8'(comb_out), 8'(exp_c), "merge");
      end
      wr(ADDR_SHORT_LOW, 8'h08);
      wr(ADDR_SHORT_HIGH, 8'h03);
      wr(ADDR_SHARED_CTL, 8'h00);
      wr(ADDR_SHORT_CTL, 8'h82);
      wait_short(1'b0, n);
      chk8(8'(n), 8'h01, "start level");
      wait_short(1'b1, n);
      wait_short(1'b0, n);
      chk8(8'(n), 8'h03, "high phase");
      wait_short(1'b1, n);
      chk8(8'(n), 8'h08, "low phase");
      wr(ADDR_SHORT_HIGH, 8'h06);
      #1;
      wait_short(1'b0, n);
      chk8(8'(n + 2), 8'h03, "old reload kept");
      wait_short(1'b1, n);
      wait_short(1'b0, n);
      chk8(8'(n), 8'h06, "new reload");
      rdchk(ADDR_SHORT_CTL, 8'ha2, "timeout status");
      chk8(8'(to_pulses), 8'h06, "timeout requests");
      wr(ADDR_SHORT_CTL, 8'h02);
      wr(ADDR_SHORT_CTL, 8'h20);
      rdchk(ADDR_SHORT_CTL, 8'h00, "status cleared");
      wr(ADDR_SHARED_CTL, 8'h02);
      wr(ADDR_SHORT_HIGH, 8'h04);
      wr(ADDR_SHORT_CTL, 8'hc0);
      wait_short(1'b1, n);
      wait_short(1'b0, n);
      chk8(8'(n), 8'h04, "single pass");
      repeat (20) @(posedge clk_sys);
      #1;
      chk8(8'(short_out), 8'h00, "stopped");
      chk8(8'(to_pulses), 8'h06, "masked request");
      rd(ADDR_SHORT_CTL, rv);
      chk8(rv & 8'h20, 8'h20, "single pass status");
      wr(ADDR_SHORT_CTL, 8'h40);
      wr(ADDR_SHORT_CTL, 8'h20);
      // Long counter levels, then alternation and its end
      wr(ADDR_SHARED_CTL, 8'h01);
      wr(ADDR_LONG_RLD_LO, 8'h05);
      wr(ADDR_LONG_RLD_HI, 8'h00);
      #1;
      chk8(8'(long_out), 8'h00, "idle long");
      wr(ADDR_LONG_CTL, 8'hc0);
      repeat (2) @(posedge clk_sys);
      #1;
      chk8(8'(long_out), 8'h01, "long start level");
      repeat (4) @(posedge clk_sys);
      #1;
      chk8(8'(long_out), 8'h00, "long toggled");
      wr(ADDR_LONG_CTL, 8'h00);
      wr(ADDR_SHARED_CTL, 8'h05);
      wr(ADDR_LONG_CTL, 8'h80);
      wr(ADDR_SHORT_CTL, 8'h80);
      wait_short(1'b0, n);
      wait_short(1'b1, n);
      wait_short(1'b0, n);
      chk8(8'(n), 8'h0b, "high phase held");
      chk8(8'(long_out), 8'h00, "long ran in turn");
      wr(ADDR_SHARED_CTL, 8'h01);
      wait_short(1'b1, n);
      wait_short(1'b0, n);
      chk8(8'(n), 8'h04, "alternation ended");
      wr(ADDR_SHORT_CTL, 8'h00);
      wr(ADDR_LONG_CTL, 8'h00);
      wr(ADDR_SHORT_LOW, 8'h00);
      wr(ADDR_SHORT_CTL, 8'h60);
      wr(ADDR_SHORT_CTL, 8'hc0);
      wait_short(1'b0, n);
      wait_short(1'b1, n);
      chk8(8'(n - 1), 8'hff, "zero wraps");
      wr(ADDR_SHORT_CTL, 8'h40);
      wr(ADDR_SHORT_CTL, 8'h20);
      wr(ADDR_SHORT_LOW, 8'hff);
      wr(ADDR_SHORT_HIGH, 8'hff);
      wr(ADDR_SHARED_CTL, 8'ha0);
      wr(ADDR_SHORT_CTL, 8'h84);
      repeat (300) @(posedge clk_sys);
      rdchk(ADDR_SHORT_CTL, 8'h84, "armed without edge");
      edge_to(1'b1, 20);
      edge_to(1'b0, 20);
      edge_to(1'b1, 15);
      edge_to(1'b0, 10);
      rd(ADDR_POS_CAP, cap_pos);
      rd(ADDR_NEG_CAP, rv);
      chk8(cap_pos - rv, 8'h05, "capture spacing");
      chk8(8'(cap_pulses), 8'h03, "capture requests");
      rdchk(ADDR_SHARED_CTL, 8'ha3, "edge flags");
      wr(ADDR_SHARED_CTL, 8'ha3);
      rdchk(ADDR_SHARED_CTL, 8'ha0, "flags cleared");
      wr(ADDR_SHARED_CTL, 8'h90);
      edge_to(1'b1, 10);
      edge_to(1'b0, 10);
      rdchk(ADDR_SHARED_CTL, 8'h92, "rising only");
      chk8(8'(cap_pulses), 8'h04, "one capture");
      repeat (300) @(posedge clk_sys);
      rd(ADDR_SHORT_CTL, rv);
      chk8(rv & 8'h20, 8'h20, "demod timeout");
      // Two-cycle pulse is no longer than the first glitch width
      wr(ADDR_SHARED_CTL, 8'h96);
      edge_to(1'b1, 1);
      edge_to(1'b0, 10);
      rdchk(ADDR_SHARED_CTL, 8'h94, "glitch removed");
      edge_to(1'b1, 10);
      rdchk(ADDR_SHARED_CTL, 8'h96, "edge passed");
      wrap_up();
   end
endmodule : tb_top
